// ---- design/sram_pkg.sv ----
/*
  Constants shared by the pipelined burst memory core and its array.
  Assumes one 25 MHz clock and a synchronous active-low reset.
*/
// Contract
// - Register every synchronous input on rising edge
// - Load address only when a strobe asserted
// - Step burst address only on advance
// - Two-bit burst counter, four locations
// - Interleaved or linear order, user selected
// - Registered write completes without further timing
// - Byte-lane writes of selected lanes only
// - All-bytes write updates every lane
// - Output enable and sleep act unclocked
// - Registered outputs, pipelined three-one-one-one reads
// - Deselect takes effect in one cycle
// - Two independent address strobes start accesses
// - Array 512K x 36 or 1M x 18
// - Both strobes: processor strobe wins
// - Output enable masked first read clock after deselect or reset
package sram_pkg;
  localparam int ADDR_W_X36  = 19;
  localparam int ADDR_W_X18  = 20;
  localparam int DATA_W_X36  = 36;
  localparam int LANE_BITS   = 9;
  localparam int BURST_W     = 2;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam int PIPE_DEPTH  = 2;
endpackage : sram_pkg

// ---- design/sram_array.sv ----
/*
  Storage array with registered read port and per-lane write.
  Assumes writes and reads share one clock; no reset on the cells.
*/
`timescale 1ns/10ps
module sram_array #(
  parameter int AW    = sram_pkg::ADDR_W_X36,
  parameter int LANES = 4,
  parameter int LW    = sram_pkg::LANE_BITS
) (
  input  wire logic                clk,
  input  wire logic [AW-1:0]       addr,
  input  wire logic                wrEn,
  input  wire logic [LANES-1:0]    laneEn,
  input  wire logic [LANES*LW-1:0] wrData,
  output logic      [LANES*LW-1:0] rdData
);
  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : gLane
      always_ff @(posedge clk)
      begin
        if (wrEn && laneEn[g])
          mem[addr][g*LW +: LW] <= wrData[g*LW +: LW];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    rdData <= mem[addr];
  end
endmodule : sram_array

// ---- design/pipelined_burst_sync_sram.sv ----
/*
  Pipelined synchronous burst memory: registered inputs, burst counter,
  byte writes, registered outputs, unclocked output enable and sleep.
  Assumes the master drives all synchronous pins from the clk domain.
*/
`timescale 1ns/10ps
module pipelined_burst_sync_sram #(
  parameter int AW    = sram_pkg::ADDR_W_X36,
  parameter int LANES = sram_pkg::DATA_W_X36 / sram_pkg::LANE_BITS,
  parameter int LW    = sram_pkg::LANE_BITS
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [AW-1:0]       addr,
  input  wire logic                processor_addr_strobe_n,
  input  wire logic                controller_addr_strobe_n,
  input  wire logic                burst_advance_n,
  input  wire logic                all_bytes_write_n,
  input  wire logic                byte_write_enable_n,
  input  wire logic [LANES-1:0]    byte_lane_select_n,
  input  wire logic                chip_select_primary_n,
  input  wire logic                chip_select_depth_hi,
  input  wire logic                chip_select_depth_lo_n,
  input  wire logic                linearOrder,
  input  wire logic                outputEnable_n,
  input  wire logic                sleep_request,
  input  wire logic [LANES*LW-1:0] dataIn,
  output logic      [LANES*LW-1:0] dataOut,
  output logic                     dataOutEn
);
  localparam int DW = LANES * LW;

  // Input registers
  logic [AW-1:0]    addrIn_reg,  addrIn_next;
  logic             procStbIn_reg, procStbIn_next;
  logic             ctrlStbIn_reg, ctrlStbIn_next;
  logic             stepIn_reg,    stepIn_next;
  logic             allWrIn_reg,   allWrIn_next;
  logic             laneWrIn_reg,  laneWrIn_next;
  logic [LANES-1:0] laneSelIn_reg, laneSelIn_next;
  logic             csPriIn_reg,   csPriIn_next;
  logic             csHiIn_reg,    csHiIn_next;
  logic             csLoIn_reg,    csLoIn_next;
  logic [DW-1:0]    dIn_reg,       dIn_next;

  always_comb
  begin
    addrIn_next    = addr;
    procStbIn_next = processor_addr_strobe_n;
    ctrlStbIn_next = controller_addr_strobe_n;
    stepIn_next    = burst_advance_n;
    allWrIn_next   = all_bytes_write_n;
    laneWrIn_next  = byte_write_enable_n;
    laneSelIn_next = byte_lane_select_n;
    csPriIn_next   = chip_select_primary_n;
    csHiIn_next    = chip_select_depth_hi;
    csLoIn_next    = chip_select_depth_lo_n;
    dIn_next       = dataIn;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      addrIn_reg    <= '0;
      procStbIn_reg <= 1'b1;
      ctrlStbIn_reg <= 1'b1;
      stepIn_reg    <= 1'b1;
      allWrIn_reg   <= 1'b1;
      laneWrIn_reg  <= 1'b1;
      laneSelIn_reg <= '1;
      csPriIn_reg   <= 1'b1;
      csHiIn_reg    <= 1'b0;
      csLoIn_reg    <= 1'b1;
      dIn_reg       <= '0;
    end
    else
    begin
      addrIn_reg    <= addrIn_next;
      procStbIn_reg <= procStbIn_next;
      ctrlStbIn_reg <= ctrlStbIn_next;
      stepIn_reg    <= stepIn_next;
      allWrIn_reg   <= allWrIn_next;
      laneWrIn_reg  <= laneWrIn_next;
      laneSelIn_reg <= laneSelIn_next;
      csPriIn_reg   <= csPriIn_next;
      csHiIn_reg    <= csHiIn_next;
      csLoIn_reg    <= csLoIn_next;
      dIn_reg       <= dIn_next;
    end
  end

  // Access control state
  logic [AW-1:0]               base_reg,   base_next;
  logic [sram_pkg::BURST_W-1:0] count_reg, count_next;
  logic                        sel_reg,    sel_next;
  logic                        fromDesel_reg, fromDesel_next;
  logic [sram_pkg::PIPE_DEPTH-1:0] rdPipe_reg, rdPipe_next;
  logic [sram_pkg::PIPE_DEPTH-1:0] mask_reg,   mask_next;
  logic [DW-1:0]               q_reg,      q_next;

  logic                        procStrobe;
  logic                        ctrlStrobe;
  logic                        load;
  logic                        csActive;
  logic                        selNow;
  logic                        isWrite;
  logic [LANES-1:0]            laneEn;
  logic [sram_pkg::BURST_W-1:0] startLow;
  logic [sram_pkg::BURST_W-1:0] lowBits;
  logic [AW-1:0]               arrAddr;
  logic [DW-1:0]               arrData;

  always_comb
  begin
    csActive   = !csPriIn_reg && csHiIn_reg && !csLoIn_reg;
    // Processor strobe is ignored while primary select is high
    procStrobe = !procStbIn_reg && !csPriIn_reg;
    ctrlStrobe = !ctrlStbIn_reg && procStbIn_reg;
    load       = procStrobe || ctrlStrobe;
    base_next  = base_reg;
    count_next = count_reg;
    sel_next   = sel_reg;
    if (load)
    begin
      base_next  = addrIn_reg;
      count_next = sram_pkg::BURST_RESET;
      sel_next   = csActive;
    end
    else if (!ctrlStbIn_reg && !csActive)
      sel_next = 1'b0;
    else if (!stepIn_reg && sel_reg)
      count_next = count_reg + 2'h1;
    selNow   = load ? csActive : sel_next;
    startLow = load ? addrIn_reg[1:0] : base_reg[1:0];
    // Interleave is xor of start, linear is sum modulo four
    if (linearOrder)
      lowBits = startLow + count_next;
    else
      lowBits = startLow ^ count_next;
    arrAddr = {(load ? addrIn_reg[AW-1:2] : base_reg[AW-1:2]), lowBits};
    // Processor-strobe cycles are always reads first
    isWrite = selNow && !procStrobe &&
              (!allWrIn_reg || (!laneWrIn_reg && (laneSelIn_reg != '1)));
    laneEn  = !allWrIn_reg ? '1 : ~laneSelIn_reg;
    arrData = dIn_reg;
    fromDesel_next = !selNow;
    rdPipe_next = {rdPipe_reg[0], selNow && !isWrite};
    mask_next   = {mask_reg[0], selNow && !isWrite && fromDesel_reg};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      base_reg      <= '0;
      count_reg     <= sram_pkg::BURST_RESET;
      sel_reg       <= 1'b0;
      fromDesel_reg <= 1'b1;
      rdPipe_reg    <= '0;
      mask_reg      <= '0;
    end
    else
    begin
      base_reg      <= base_next;
      count_reg     <= count_next;
      sel_reg       <= sel_next;
      fromDesel_reg <= fromDesel_next;
      rdPipe_reg    <= rdPipe_next;
      mask_reg      <= mask_next;
    end
  end

  logic [DW-1:0] arrQ;

  sram_array #(
    .AW    (AW),
    .LANES (LANES),
    .LW    (LW)
  ) uArray (
    .clk    (clk),
    .addr   (arrAddr),
    .wrEn   (isWrite && !sleep_request),
    .laneEn (laneEn),
    .wrData (arrData),
    .rdData (arrQ)
  );

  always_comb
  begin
    q_next = rdPipe_reg[0] ? arrQ : q_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign dataOut = q_reg;
  // Enable is combinational so it follows the pins without a clock
  assign dataOutEn = !outputEnable_n && !sleep_request && rdPipe_reg[1] &&
                     !mask_reg[1];
endmodule : pipelined_burst_sync_sram

// ---- testbench/bus_master_model.sv ----
/* Master model: one synchronous bus cycle per op call.
   Assumes the memory samples its pins on the rising clk edge. */
`timescale 1ns/10ps
module bus_master_model (
  input  wire logic        clk,
  output logic      [18:0] addr   = 19'h0_0000,
  output logic      [35:0] dIn    = 36'h0_0000_0000,
  output logic      [3:0]  lane_n = 4'hF,
  output logic      [7:0]  ctl_n  = 8'hFE
);
  // Idle, write all, write lanes, read, advance, deselect
  localparam logic [7:0] KIND [6] = '{8'hFE, 8'hAA, 8'hB2, 8'h2A,
    8'hDA, 8'hB8};
  task automatic op(int k, logic [18:0] a, logic [35:0] d, logic [3:0] l);
    @(posedge clk);
    #1;
    {ctl_n, addr, dIn, lane_n} = {KIND[k], a, d, l};
  endtask : op
endmodule : bus_master_model

// ---- testbench/sram_core_assertions.sv ----
/* Port checker for the burst memory core.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module sram_core_assertions #(parameter int DW = 36) (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          processor_addr_strobe_n,
  input wire logic          controller_addr_strobe_n,
  input wire logic          burst_advance_n,
  input wire logic          all_bytes_write_n,
  input wire logic          byte_write_enable_n,
  input wire logic          chip_select_primary_n,
  input wire logic          chip_select_depth_hi,
  input wire logic          chip_select_depth_lo_n,
  input wire logic          outputEnable_n,
  input wire logic          sleep_request,
  input wire logic [DW-1:0] dataOut,
  input wire logic          dataOutEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic rest  = all_bytes_write_n && byte_write_enable_n &&
                     processor_addr_strobe_n && controller_addr_strobe_n;
  wire logic quiet = !outputEnable_n && !sleep_request;
  wire logic rd    = !processor_addr_strobe_n && !chip_select_primary_n &&
                     chip_select_depth_hi && !chip_select_depth_lo_n;
  wire logic desel = processor_addr_strobe_n && !controller_addr_strobe_n &&
                     !chip_select_depth_hi;
  reset_clear_a: assert property (disable iff (1'h0)
    !rstn |=> dataOut == '0 && !dataOutEn) else $error("reset not clear");
  oe_gate_a: assert property (outputEnable_n |-> !dataOutEn)
    else $error("driven with enable off");
  sleep_gate_a: assert property (sleep_request |-> !dataOutEn)
    else $error("driven while asleep");
  // Four rest cycles so a suspended re-read sees no fresh write
  idle_hold_a: assert property ((rest && burst_advance_n) [*4] |=>
    $stable(dataOut)) else $error("data changed without read");
  deselect_off_a: assert property (desel ##1
    (rest && burst_advance_n) [*3] |-> !dataOutEn) else $error("deselect");
  first_masked_a: assert property (desel ##1
    (rest && burst_advance_n) [*3] ##1 rd |-> ##3 !dataOutEn)
    else $error("first beat driven");
  read_pair_a: assert property (rd ##1 rd |-> ##3
    (dataOutEn || !quiet)) else $error("read beat late");
  advance_beat_a: assert property (rd ##1 rd ##1
    (rest && !burst_advance_n) |-> ##3 (dataOutEn || !quiet))
    else $error("advance beat late");
  cover property (rd ##1 rd ##1 (rest && !burst_advance_n));
  cover property (desel ##1 (rest && burst_advance_n) [*3] ##1 rd);
  cover property ((rest && burst_advance_n) [*4]);
endmodule : sram_core_assertions
bind pipelined_burst_sync_sram sram_core_assertions #(.DW(LANES*LW)) i_chk
  (.*);

// ---- testbench/pipelined_burst_sync_sram_test.sv ----
/* Random bursts and byte writes checked against a local copy.
   Assumes the master model drives every synchronous pin. */
`timescale 1ns/10ps
module pipelined_burst_sync_sram_test;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        linearOrder = 1'h0;
  logic        oe_n = 1'h0;
  logic        sleep = 1'h0;
  logic [18:0] addr;
  logic [35:0] dIn, dataOut;
  logic [3:0]  lane_n;
  logic [7:0]  ctl_n;
  logic        dataOutEn;
  logic [35:0] mem [logic [18:0]];
  logic [31:0] seed = 32'h0000_7ED1;
  int          errCount = 0;
  int          checks = 0;
  always #20 clk = ~clk;
  bus_master_model i_bus_master_model (.clk, .addr, .dIn, .lane_n, .ctl_n);
  pipelined_burst_sync_sram i_pipelined_burst_sync_sram (.clk, .rstn,
    .addr, .processor_addr_strobe_n(ctl_n[7]),
    .controller_addr_strobe_n(ctl_n[6]), .burst_advance_n(ctl_n[5]),
    .all_bytes_write_n(ctl_n[4]), .byte_write_enable_n(ctl_n[3]),
    .byte_lane_select_n(lane_n), .chip_select_primary_n(ctl_n[2]),
    .chip_select_depth_hi(ctl_n[1]), .chip_select_depth_lo_n(ctl_n[0]),
    .linearOrder, .outputEnable_n(oe_n), .sleep_request(sleep),
    .dataIn(dIn), .dataOut, .dataOutEn);
  function automatic logic [35:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return {seed, seed[3:0] ^ seed[31:28]};
  endfunction : rnd
  function automatic logic [18:0] nxt(logic [18:0] b, int i);
    return {b[18:2], linearOrder ? b[1:0] + 2'(i) : b[1:0] ^ 2'(i)};
  endfunction : nxt
  task automatic check(logic [35:0] got, logic [35:0] want);
    checks++;
    if (got !== want)
    begin
      errCount++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d checks %0d", errCount, checks);
    if (errCount == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    #100000;
    errCount++;
    end_of_test();
  end
  initial
  begin
    logic [18:0] base;
    logic [35:0] d;
    logic [3:0]  l;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'h1;
    for (int g = 0; g < 8; g++)
    begin
      linearOrder = g[0];
      base = 19'(rnd()) & 19'h7_FFFC;
      for (int i = 0; i < 4; i++)
      begin
        d = rnd();
        mem[base + 19'(i)] = d;
        i_bus_master_model.op(1, base + 19'(i), d, 4'(rnd()));
      end
      {l, base[1:0]} = 6'(rnd());
      d = rnd();
      for (int k = 0; k < 4; k++)
        if (!l[k])
          mem[base][9*k +: 9] = d[9*k +: 9];
      i_bus_master_model.op(2, base, d, l);
      i_bus_master_model.op(5, base, ~d, l);
      repeat (3) i_bus_master_model.op(0, base, ~d, l);
      check(36'(dataOutEn), 36'h0);
      // Read strobe also carries a controller write that must lose
      for (int i = 0; i < 7; i++)
      begin
        i_bus_master_model.op(i == 0 ? 3 : (i < 4 ? 4 : 0), base, ~d, l);
        if (i >= 3)
        begin
          check(dataOut, mem[nxt(base, i - 3)]);
          for (int s = 3; s >= 0; s--)
          begin
            {oe_n, sleep} = 2'(s);
            #1 check(36'(dataOutEn), 36'(s == 0 && i > 3));
          end
        end
      end
    end
    // Write while asleep must leave the word untouched
    sleep = 1'h1;
    i_bus_master_model.op(1, base, ~mem[base], l);
    repeat (2) i_bus_master_model.op(0, base, d, l);
    sleep = 1'h0;
    for (int i = 0; i < 7; i++)
    begin
      i_bus_master_model.op(i < 2 ? 3 : (i == 2 ? 4 : 0), base, d, l);
      if (i == 2)
        check(dataOut, mem[base]);
    end
    end_of_test();
  end
endmodule : pipelined_burst_sync_sram_test
